// ==== logic/mbu_barrier.sv ====
// Behaviour
// - Completion: older accesses globally performed before younger ones
// - Instruction fetches are never held by the barrier
// - Type zero is the full load and store completion barrier
// - Undefined and reserved type codes act exactly like type zero
// - Every completion barrier flushes all pending writes first
// - External request only when software and hardware enables both set
// - Wait for pending reads and any external response before completing
// - Type 0x2 coherent request when coherent; otherwise acts as zero
// - Type 0x3 coherent request, forwarded to memory, maybe externalized
// - Type 0x3 response follows prior requests and external response
// - Coherent type zero maps to 0x2 or 0x3 by select bit
// - Non-coherent type zero sends legacy request straight to memory
// - Ordering: older accesses reach ordering point before younger ones
// - Older external requests globally performed before younger ones
// - Ordering types alike: flush evictions, stop merging, no waiting
// - Cache and prefetch operations count as loads and stores
// - Type field bits 10:6; 0x4 stores, 0x10 all, 0x13 loads
// - Acquire and release order without global performance
// - Load done at register write, store done when globally visible
`timescale 1ns/1ps
module mbu_barrier (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic BARRIER_ISSUE,
    input wire logic [31:0] BARRIER_INSTR,
    input wire logic COHERENCE_ENABLE,
    input wire logic COHERENT_BARRIER_TYPE_SELECT,
    input wire logic EXTERNAL_BARRIER_SW_ENABLE,
    input wire logic BARRIER_TXN_HW_ENABLE_IN,
    input wire logic PENDING_WRITES,
    input wire logic PENDING_READS,
    input wire logic PENDING_EVICTIONS,
    input wire logic COHERENT_BARRIER_RESP,
    input wire logic LEGACY_BARRIER_RESP,
    input wire logic EXT_BARRIER_RESP,
    output logic BARRIER_BUSY,
    output logic BARRIER_DONE,
    output logic STALL_YOUNGER_LOADS,
    output logic STALL_YOUNGER_STORES,
    output logic FLUSH_WRITES,
    output logic FLUSH_EVICTIONS,
    output logic STOP_WBB_MERGE,
    output logic COHERENT_BARRIER_REQUEST,
    output logic COHERENT_BARRIER_MEM,
    output logic LEGACY_BARRIER_REQ,
    output logic EXT_BARRIER_REQ,
    output logic [4:0] ACTIVE_STYPE
);

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    // Ordering codes; everything else is a full completion barrier
    function automatic logic is_ordering(input logic [4:0] t);
        return t == mbu_pkg::STYPE_WMB || t == mbu_pkg::STYPE_MB ||
            t == mbu_pkg::STYPE_ACQ || t == mbu_pkg::STYPE_REL ||
            t == mbu_pkg::STYPE_RMB;
    endfunction

    // Older classes ordered / younger classes held, per code
    function automatic mbu_pkg::mbu_cls_t older_cls(input logic [4:0] t);
        case (t)
            mbu_pkg::STYPE_WMB: return '{ld: 1'b0, st: 1'b1};
            mbu_pkg::STYPE_ACQ: return '{ld: 1'b1, st: 1'b0};
            mbu_pkg::STYPE_RMB: return '{ld: 1'b1, st: 1'b0};
            default: return '{ld: 1'b1, st: 1'b1};
        endcase
    endfunction

    function automatic mbu_pkg::mbu_cls_t younger_cls(input logic [4:0] t);
        case (t)
            mbu_pkg::STYPE_WMB: return '{ld: 1'b0, st: 1'b1};
            mbu_pkg::STYPE_REL: return '{ld: 1'b0, st: 1'b1};
            mbu_pkg::STYPE_RMB: return '{ld: 1'b1, st: 1'b0};
            default: return '{ld: 1'b1, st: 1'b1};
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mbu_pkg::mbu_regs_t r_q;
    mbu_pkg::mbu_regs_t r_d;
    logic [4:0] new_type;
    logic ext_ok;
    logic resp_seen;
    logic reads_idle;
    // Request bits are cleared in the request state, so remember the external one
    logic ext_pending_q;

    assign new_type = BARRIER_INSTR[mbu_pkg::STYPE_MSB:mbu_pkg::STYPE_LSB];
    assign ext_ok = EXTERNAL_BARRIER_SW_ENABLE &
        BARRIER_TXN_HW_ENABLE_IN;
    // Pending counts cover cache and prefetch traffic as well
    assign reads_idle = !PENDING_READS;
    assign resp_seen = r_q.use_coh ? COHERENT_BARRIER_RESP
                     : (ext_pending_q ? EXT_BARRIER_RESP
                                        : LEGACY_BARRIER_RESP);

    always_comb begin
        r_d = r_q;
        r_d.done = 1'b0;
        case (r_q.state)
            mbu_pkg::MBU_IDLE: begin
                if (BARRIER_ISSUE) begin
                    r_d.stype = new_type;
                    r_d.completion = !is_ordering(new_type);
                    r_d.older = older_cls(new_type);
                    r_d.younger = younger_cls(new_type);
                    // Type 0x2 and 0x3 fall back to zero when non-coherent
                    r_d.use_coh = COHERENCE_ENABLE;
                    if (new_type == mbu_pkg::STYPE_MEM)
                        r_d.mem_sync = 1'b1;
                    else if (new_type == mbu_pkg::STYPE_INTV)
                        r_d.mem_sync = 1'b0;
                    else
                        r_d.mem_sync = COHERENT_BARRIER_TYPE_SELECT;
                    r_d.ext_sel = ext_ok;
                    r_d.busy = 1'b1;
                    if (is_ordering(new_type)) begin
                        r_d.evict_flush = 1'b1;
                        r_d.stop_merge = 1'b1;
                        r_d.state = mbu_pkg::MBU_ORDER;
                    end else begin
                        r_d.flush_writes = 1'b1;
                        r_d.state = mbu_pkg::MBU_DRAIN;
                    end
                end
            end
            mbu_pkg::MBU_ORDER: begin
                // In-order core: evictions out means older reached the point
                if (!PENDING_EVICTIONS) begin
                    r_d.evict_flush = 1'b0;
                    r_d.stop_merge = 1'b0;
                    r_d.state = mbu_pkg::MBU_DONE;
                end
            end
            mbu_pkg::MBU_DRAIN: begin
                if (!PENDING_WRITES && reads_idle) begin
                    r_d.flush_writes = 1'b0;
                    if (r_q.use_coh) begin
                        r_d.req.coh_req = 1'b1;
                    end else begin
                        r_d.req.legacy_req = 1'b1;
                        r_d.req.ext_req = r_q.ext_sel;
                    end
                    r_d.state = mbu_pkg::MBU_REQ;
                end
            end
            mbu_pkg::MBU_REQ: begin
                // Request is a one-cycle pulse
                r_d.req = '0;
                r_d.state = mbu_pkg::MBU_WAIT;
                if (r_q.req.ext_req)
                    r_d.req.ext_req = 1'b0;
            end
            mbu_pkg::MBU_WAIT: begin
                // Coherent 0x3 answer already covers the external one
                if (resp_seen && reads_idle) begin
                    r_d.state = mbu_pkg::MBU_DONE;
                end
            end
            mbu_pkg::MBU_DONE: begin
                r_d.done = 1'b1;
                r_d.busy = 1'b0;
                r_d.state = mbu_pkg::MBU_IDLE;
            end
            default: r_d.state = mbu_pkg::MBU_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            r_q <= '0;
            r_q.state <= mbu_pkg::MBU_IDLE;
            r_q.stype <= mbu_pkg::STYPE_RST;
            ext_pending_q <= 1'b0;
        end else begin
            r_q <= r_d;
            if (r_q.state == mbu_pkg::MBU_REQ)
                ext_pending_q <= r_q.req.ext_req;
            else if (r_q.state == mbu_pkg::MBU_IDLE)
                ext_pending_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Fetches are never stalled: no fetch port exists here
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            BARRIER_BUSY <= 1'b0;
            BARRIER_DONE <= 1'b0;
            STALL_YOUNGER_LOADS <= 1'b0;
            STALL_YOUNGER_STORES <= 1'b0;
            FLUSH_WRITES <= 1'b0;
            FLUSH_EVICTIONS <= 1'b0;
            STOP_WBB_MERGE <= 1'b0;
            COHERENT_BARRIER_REQUEST <= 1'b0;
            COHERENT_BARRIER_MEM <= 1'b0;
            LEGACY_BARRIER_REQ <= 1'b0;
            EXT_BARRIER_REQ <= 1'b0;
            ACTIVE_STYPE <= mbu_pkg::STYPE_RST;
        end else begin
            BARRIER_BUSY <= r_d.busy;
            BARRIER_DONE <= r_d.done;
            STALL_YOUNGER_LOADS <= r_d.busy & r_d.younger.ld;
            STALL_YOUNGER_STORES <= r_d.busy & r_d.younger.st;
            FLUSH_WRITES <= r_d.flush_writes;
            FLUSH_EVICTIONS <= r_d.evict_flush;
            STOP_WBB_MERGE <= r_d.stop_merge;
            COHERENT_BARRIER_REQUEST <= r_d.req.coh_req;
            // Memory-sync flag and external enable travel with the request
            COHERENT_BARRIER_MEM <= r_d.req.coh_req & r_d.mem_sync;
            LEGACY_BARRIER_REQ <= r_d.req.legacy_req;
            EXT_BARRIER_REQ <= r_d.req.ext_req |
                (r_d.req.coh_req & r_d.mem_sync & r_d.ext_sel);
            ACTIVE_STYPE <= r_d.stype;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_drain_clear;
        !PENDING_WRITES && !PENDING_READS;
    endsequence

    // Retire step: done state, then the completion pulse with busy low
    sequence s_finish;
        r_q.state == mbu_pkg::MBU_DONE ##1 BARRIER_DONE && !BARRIER_BUSY;
    endsequence

    AST_EXT_NEEDS_ENABLES: assert property (@(posedge CORE_CLK)
        disable iff (RESET) EXT_BARRIER_REQ |-> $past(r_q.ext_sel))
        else $error("External barrier request without both enables");

    AST_ORDER_NO_EXT: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_ORDER) |->
        !EXT_BARRIER_REQ && !LEGACY_BARRIER_REQ && !COHERENT_BARRIER_REQUEST)
        else $error("Ordering barrier sent a request");

    AST_RESERVED_FULL: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_IDLE && BARRIER_ISSUE
        && !is_ordering(new_type)) |=> r_q.state == mbu_pkg::MBU_DRAIN)
        else $error("Non-ordering code not run as completion barrier");

    AST_FLUSH_ON_COMPLETION: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_DRAIN) |-> ##1
        FLUSH_WRITES || r_q.state == mbu_pkg::MBU_REQ)
        else $error("Pending writes not flushed");

    AST_REQ_AFTER_DRAIN: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_DRAIN ##1
        r_q.state == mbu_pkg::MBU_REQ) |->
        $past(!PENDING_WRITES && !PENDING_READS))
        else $error("Request sent with reads or writes pending");

    AST_DRAIN_EXIT: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_DRAIN) ##0
        s_drain_clear |=> r_q.state == mbu_pkg::MBU_REQ && !FLUSH_WRITES)
        else $error("Drained barrier did not move to request");

    AST_DRAIN_HOLDS: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_DRAIN &&
        PENDING_WRITES) |=> r_q.state == mbu_pkg::MBU_DRAIN && FLUSH_WRITES)
        else $error("Barrier left drain with writes pending");

    AST_WAIT_HOLDS: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_WAIT &&
        !(resp_seen && reads_idle)) |=>
        r_q.state == mbu_pkg::MBU_WAIT && BARRIER_BUSY)
        else $error("Barrier completed without its response");

    AST_WAIT_FINISH: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_WAIT && resp_seen &&
        reads_idle) |=> s_finish)
        else $error("Answered barrier did not complete");

    AST_ORDER_FINISH: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_ORDER &&
        !PENDING_EVICTIONS) |=> s_finish)
        else $error("Ordering barrier waited past its evictions");

    AST_ORDER_FLUSH: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_ORDER) |->
        FLUSH_EVICTIONS && STOP_WBB_MERGE && !FLUSH_WRITES)
        else $error("Ordering barrier without eviction flush");

    AST_COH_MEM_EXT: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (COHERENT_BARRIER_REQUEST &&
        COHERENT_BARRIER_MEM) |-> EXT_BARRIER_REQ == r_q.ext_sel)
        else $error("Memory barrier external request mismatch");

    AST_COH_INTV: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (COHERENT_BARRIER_REQUEST &&
        r_q.stype == mbu_pkg::STYPE_INTV) |->
        !COHERENT_BARRIER_MEM && !EXT_BARRIER_REQ)
        else $error("Intervention barrier went to memory");

    AST_NONCOH_LEGACY: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (r_q.state == mbu_pkg::MBU_REQ &&
        !r_q.use_coh) |-> LEGACY_BARRIER_REQ && !COHERENT_BARRIER_REQUEST
        && EXT_BARRIER_REQ == r_q.ext_sel)
        else $error("Non-coherent barrier request wrong");

    AST_COMPLETION_STALLS: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (BARRIER_BUSY && r_q.completion) |->
        STALL_YOUNGER_LOADS && STALL_YOUNGER_STORES)
        else $error("Completion barrier not stalling all accesses");

    AST_REQ_PULSE: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (COHERENT_BARRIER_REQUEST || LEGACY_BARRIER_REQ)
        |=> !COHERENT_BARRIER_REQUEST && !LEGACY_BARRIER_REQ &&
        !EXT_BARRIER_REQ)
        else $error("Barrier request longer than one cycle");

    AST_LEGACY_NONCOH: assert property (@(posedge CORE_CLK)
        disable iff (RESET) LEGACY_BARRIER_REQ |-> !r_q.use_coh)
        else $error("Legacy request while coherent");

    // Next issue may land right after the pulse, so busy is checked with it
    AST_DONE_PULSE: assert property (@(posedge CORE_CLK)
        disable iff (RESET) BARRIER_DONE |-> !BARRIER_BUSY ##1 !BARRIER_DONE)
        else $error("Completion not a single pulse");

    AST_STORE_ORDER_LOADS_FREE: assert property (@(posedge CORE_CLK)
        disable iff (RESET) (BARRIER_ISSUE && !BARRIER_BUSY &&
        r_q.state == mbu_pkg::MBU_IDLE && new_type == mbu_pkg::STYPE_WMB)
        |=> STALL_YOUNGER_STORES && !STALL_YOUNGER_LOADS)
        else $error("Store barrier stalls wrong class");

endmodule

// ==== logic/mbu_pkg.sv ====
package mbu_pkg;

    // ------------------------------------------------------------
    // Barrier type field
    // ------------------------------------------------------------
    localparam int STYPE_LSB = 6;
    localparam int STYPE_MSB = 10;
    localparam logic [4:0] STYPE_FULL = 5'h00;
    localparam logic [4:0] STYPE_INTV = 5'h02;
    localparam logic [4:0] STYPE_MEM = 5'h03;
    localparam logic [4:0] STYPE_WMB = 5'h04;
    localparam logic [4:0] STYPE_MB = 5'h10;
    localparam logic [4:0] STYPE_ACQ = 5'h11;
    localparam logic [4:0] STYPE_REL = 5'h12;
    localparam logic [4:0] STYPE_RMB = 5'h13;
    localparam logic [4:0] STYPE_RST = 5'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MBU_IDLE,
        MBU_ORDER,
        MBU_DRAIN,
        MBU_REQ,
        MBU_WAIT,
        MBU_DONE
    } mbu_state_t;

    // Access classes: bit 1 loads, bit 0 stores
    typedef struct packed {
        logic ld;
        logic st;
    } mbu_cls_t;

    // Requests toward coherence unit / memory side
    typedef struct packed {
        logic coh_req;
        logic legacy_req;
        logic ext_req;
    } mbu_req_t;

    typedef struct packed {
        mbu_state_t state;
        logic [4:0] stype;
        logic completion;
        logic use_coh;
        logic mem_sync;
        logic ext_sel;
        mbu_cls_t older;
        mbu_cls_t younger;
        mbu_req_t req;
        logic flush_writes;
        logic evict_flush;
        logic stop_merge;
        logic busy;
        logic done;
    } mbu_regs_t;

endpackage

// ==== test/mbu_far_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Coherence unit and memory side, answering barrier requests
// ------------------------------------------------------------
module mbu_far_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic coh_req,
    input wire logic leg_req,
    input wire logic ext_req,
    input wire logic done,
    input wire logic [3:0] delay,
    input wire logic [2:0] mute,
    output logic coh_resp,
    output logic leg_resp,
    output logic ext_resp
);
    logic [2:0] pend;
    logic [3:0] cnt;

    // Answers stay up until the core retires the barrier
    always_ff @(posedge clk) begin
        if (rst || done) begin
            pend <= 3'h0;
            cnt <= 4'h0;
        end else begin
            pend <= pend | {coh_req, leg_req, ext_req};
            if (pend != 3'h0 && cnt != delay)
                cnt <= cnt + 4'h1;
        end
    end

    // Mute stands for a response that is late or never comes
    assign {coh_resp, leg_resp, ext_resp} =
        (pend != 3'h0 && cnt == delay) ?
        pend & ~mute : 3'h0;
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, (e) === (g), 32'(e), 32'(g))
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issue = 1'b0;
    logic coh = 1'b0, sel = 1'b0, sw = 1'b0, hw = 1'b0;
    logic pw = 1'b0, pr = 1'b0, pe = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [3:0] dly = 4'h0;
    logic [2:0] mute = 3'h0;
    logic busy, done, sl, ss, fw, fe, sm, cr, cm, lr, er;
    logic c_rsp, l_rsp, e_rsp;
    logic [4:0] act;
    logic [8:0] seen;
    logic [8:0] e9;
    int cyc;
    int mismatches = 0;
    int n_checks = 0;

    mbu_barrier dut (.CORE_CLK(clk), .RESET(rst), .BARRIER_ISSUE(issue),
        .BARRIER_INSTR(instr), .COHERENCE_ENABLE(coh),
        .COHERENT_BARRIER_TYPE_SELECT(sel),
        .EXTERNAL_BARRIER_SW_ENABLE(sw), .BARRIER_TXN_HW_ENABLE_IN(hw),
        .PENDING_WRITES(pw), .PENDING_READS(pr), .PENDING_EVICTIONS(pe),
        .COHERENT_BARRIER_RESP(c_rsp), .LEGACY_BARRIER_RESP(l_rsp),
        .EXT_BARRIER_RESP(e_rsp), .BARRIER_BUSY(busy), .BARRIER_DONE(done),
        .STALL_YOUNGER_LOADS(sl), .STALL_YOUNGER_STORES(ss),
        .FLUSH_WRITES(fw), .FLUSH_EVICTIONS(fe), .STOP_WBB_MERGE(sm),
        .COHERENT_BARRIER_REQUEST(cr), .COHERENT_BARRIER_MEM(cm),
        .LEGACY_BARRIER_REQ(lr), .EXT_BARRIER_REQ(er), .ACTIVE_STYPE(act));

    mbu_far_model far (.clk(clk), .rst(rst), .coh_req(cr), .leg_req(lr),
        .ext_req(er), .done(done), .delay(dly), .mute(mute),
        .coh_resp(c_rsp), .leg_resp(l_rsp), .ext_resp(e_rsp));

    initial forever #10 clk = ~clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic ok,
                         input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Ones above the field and in bits 3:0 catch a decode that strays off bits 10:6
    task automatic start(input logic [4:0] t);
        instr = {21'h1fffff, t, 6'h0f};
        issue = 1'b1;
        @(negedge clk);
        issue = 1'b0;
    endtask

    task automatic wait_done(input int lim);
        cyc = 0;
        while (done !== 1'b1 && cyc < lim) begin
            seen |= {sl, ss, fw, fe, sm, cr, cm, lr, er};
            @(negedge clk);
            cyc++;
        end
    endtask

    // Order: stall ld, stall st, flush wr, evict, no merge, coh, mem, leg, ext
    function automatic logic [8:0] expect_of(logic [4:0] t, logic [3:0] c);
        logic mem;
        mem = (t == 5'h03) || (t != 5'h02 && c[2]);
        if (t inside {5'h04, 5'h10, 5'h11, 5'h12, 5'h13})
            return {t inside {5'h10, 5'h11, 5'h13}, t != 5'h13, 7'b0110000};
        if (c[3])
            return {5'b11100, 1'b1, mem, 1'b0, mem & c[1] & c[0]};
        return {7'b1110000, 1'b1, c[1] & c[0]};
    endfunction

    // Held by a blocker, then released and expected to finish
    task automatic held(input logic [4:0] t, input logic [2:0] m,
                        input logic r);
        pr = r;
        mute = m;
        seen = 9'h0;
        start(t);
        wait_done(12);
        `CHK("held_busy", 1'b1, busy);
        pr = 1'b0;
        mute = 3'h0;
        wait_done(20);
        `CHK("released", 1'b1, done);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        `CHK("rst_busy", 1'b0, busy);
        `CHK("rst_type", 5'h00, act);
        for (int c = 0; c < 16; c++) begin
            {coh, sel, sw, hw} = c[3:0];
            for (int t = 0; t < 32; t++) begin
                dly = 4'(t % 4 * 2);
                seen = 9'h0;
                start(5'(t));
                wait_done(40);
                e9 = expect_of(5'(t), c[3:0]);
                `CHK("done", 1'b1, done);
                `CHK("stalls", e9[8:7], seen[8:7]);
                `CHK("flushes", e9[6:4], seen[6:4]);
                `CHK("reqs", e9[3:0], seen[3:0]);
                `CHK("mem_sel", e9[2], seen[2]);
                `CHK("legacy", e9[1], seen[1]);
                `CHK("stype", 5'(t), act);
            end
        end
        {coh, sel, sw, hw} = 4'h0;
        pw = 1'b1;
        seen = 9'h0;
        start(5'h00);
        wait_done(10);
        `CHK("drain_busy", 1'b1, busy);
        `CHK("drain_flush", 1'b1, fw);
        `CHK("drain_no_req", 1'b0, seen[1]);
        start(5'h13);
        pw = 1'b0;
        wait_done(20);
        `CHK("drain_done", 1'b1, done);
        `CHK("refused_type", 5'h00, act);
        pe = 1'b1;
        pr = 1'b1;
        pw = 1'b1;
        seen = 9'h0;
        start(5'h10);
        wait_done(10);
        `CHK("evict_busy", 1'b1, busy);
        `CHK("order_no_req", 4'h0, seen[3:0]);
        pe = 1'b0;
        wait_done(10);
        `CHK("order_no_wait", 1'b1, done);
        pr = 1'b0;
        pw = 1'b0;
        {coh, sel, sw, hw} = 4'h3;
        held(5'h00, 3'h1, 1'b0);
        held(5'h00, 3'h0, 1'b1);
        {coh, sel, sw, hw} = 4'hb;
        held(5'h03, 3'h4, 1'b0);
        held(5'h02, 3'h0, 1'b1);
        stop_test();
    end

    initial begin
        #400000;
        mismatches++;
        stop_test();
    end
endmodule
